// *** design/fcs_pkg.sv ***
// Package: register map, field positions and constants of the flash config/status block
package fcs_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [15:0] FCS_IDX_CFG_ONE = 16'hf221;
    localparam logic [15:0] FCS_IDX_CFG_TWO = 16'hf222;
    localparam logic [15:0] FCS_IDX_STATUS = 16'hf240;
    localparam logic [15:0] FCS_IDX_OP = 16'hf250;
    localparam logic [17:0] FCS_ADDR_CFG_ONE = {FCS_IDX_CFG_ONE, 2'b00};
    localparam logic [17:0] FCS_ADDR_CFG_TWO = {FCS_IDX_CFG_TWO, 2'b00};
    localparam logic [17:0] FCS_ADDR_STATUS = {FCS_IDX_STATUS, 2'b00};
    localparam logic [17:0] FCS_ADDR_OP = {FCS_IDX_OP, 2'b00};
    localparam int FCS_AW = 18;

    localparam logic [15:0] FCS_CFG_ONE_RST = 16'h40c0;
    localparam logic [15:0] FCS_STATUS_RST = 16'h0000;
    // Software-writable bits of the first configuration register
    localparam logic [15:0] FCS_CFG_ONE_WMASK = 16'hfff0;

    // Configuration field positions
    localparam int FCS_CFG_RM = 15;
    localparam int FCS_CFG_BL_HI = 11;
    localparam int FCS_CFG_BL_LO = 9;
    localparam int FCS_CFG_ECC = 8;
    localparam int FCS_CFG_READY_PIN_POLARITY = 7;
    localparam int FCS_CFG_IRQ_PIN_POLARITY = 6;
    localparam int FCS_CFG_OE = 5;
    localparam int FCS_CFG_RDYCONF = 4;
    localparam int FCS_CFG_BWP = 0;

    // Status field positions
    localparam int FCS_ST_ONGO = 15;
    localparam int FCS_ST_LOCK = 14;
    localparam int FCS_ST_LOAD = 13;
    localparam int FCS_ST_PROG = 12;
    localparam int FCS_ST_ERASE = 11;
    localparam int FCS_ST_ERR = 10;
    localparam int FCS_ST_SUS = 9;
    localparam int FCS_ST_RST = 7;
    localparam int FCS_ST_ONETIME_BLOCK_LOCKED = 6;

    // Operation register bits (fcs_regs does not decode this register; an access reads zero with pslverr)
    localparam int FCS_OP_INT_READY = 0;

    // Burst size codes
    typedef enum logic [2:0] {
        FCS_BL_CONT = 3'b000,
        FCS_BL_4 = 3'b001,
        FCS_BL_8 = 3'b010,
        FCS_BL_16 = 3'b011,
        FCS_BL_32 = 3'b100
    } fcs_bl_t;
    localparam int FCS_CONT_WORDS = 1024;
    localparam int FCS_CNT_W = 11;
endpackage

// *** design/fcs_regs.sv ***
// Configuration and controller status registers with APB slave and burst ready timing
`timescale 1ns/1ps

// Contract
// - Burst size field bits 11:9: continuous, 4, 8, 16, 32 words; others reserved.
// - Continuous setting delivers up to 1K words, as clocks allow.
// - Bit 8 zero applies error correction, one bypasses it.
// - Bit 7 sets ready pin polarity, one means high for ready.
// - Bit 6 sets interrupt pin polarity, one means low while busy.
// - Interrupt and ready pins float until bit 5 is written one.
// - Pin output enable clears on cold reset or written zero.
// - Bit 4 zero: ready one clock before data; one: with data.
// - Read mode zero: async reads; one: sync reads; writes always async.
// - Bit 0 is read-only boot buffer protect flag, always zero.
// - Second configuration register is reserved, no function.
// - Controller status register is read-only, resets to zero.
// - Status bit 15 shows overall device busy.
// - Status bit 14 shows access to locked buffer or block.
// - Status bits 13..11 show load, program, erase busy or error.
// - Status bit 10 shows failure, invalid command or reset cut-off.
// - Status bit 9 shows erase suspended until resumed.
// - Status bit 7 shows reset in progress.
// - Status bit 6 shows one-time block locked, refreshed at power-on.
// - Read mode selection sits at configuration bit 15.
// - First configuration register is read/write, resets to 40c0.
module fcs_regs #(
    parameter int CONT_WORDS = fcs_pkg::FCS_CONT_WORDS
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fcs_pkg::FCS_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Flash engine status (same clock)
    input wire logic eng_busy,
    input wire logic eng_lock,
    input wire logic eng_load,
    input wire logic eng_prog,
    input wire logic eng_erase,
    input wire logic eng_err,
    input wire logic eng_sus,
    input wire logic eng_reset_busy,
    input wire logic eng_int_ready,
    // One-time block lock level from the array, sampled after power-on
    input wire logic otp_lock_in,
    // Burst interface: host burst clock pin and start of a sync burst
    input wire logic burst_clk,
    input wire logic burst_start,
    // Configuration and burst status outputs to the datapath
    output logic read_mode_sel,
    output logic ecc_bypass,
    output logic [2:0] burst_size_sel,
    output logic burst_active,
    output logic data_valid,
    // Ready and interrupt pins
    output logic rdy_o,
    output logic rdy_oe,
    output logic irq_o,
    output logic irq_oe
);
    import fcs_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] cfg_one_r;
    logic [15:0] status_r;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic otp_seen_r;
    logic bclk_s1_r, bclk_s2_r, bclk_s3_r;
    logic [FCS_CNT_W-1:0] words_left_r;
    logic burst_r;
    logic rdy_r;
    logic irq_r;
    logic valid_r;
    logic word_r;

    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite;
    wire logic bclk_rise = bclk_s2_r && !bclk_s3_r;

    function automatic logic [FCS_CNT_W-1:0] burst_words(input logic [2:0] code);
        unique case (code)
            FCS_BL_4: burst_words = FCS_CNT_W'(4);
            FCS_BL_8: burst_words = FCS_CNT_W'(8);
            FCS_BL_16: burst_words = FCS_CNT_W'(16);
            FCS_BL_32: burst_words = FCS_CNT_W'(32);
            default: burst_words = FCS_CNT_W'(CONT_WORDS);
        endcase
    endfunction

    function automatic logic known_addr(input logic [FCS_AW-1:0] a);
        known_addr = (a == FCS_ADDR_CFG_ONE) || (a == FCS_ADDR_CFG_TWO) || (a == FCS_ADDR_STATUS);
    endfunction

    // ------------------------------------------------------------
    // Configuration register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_one_r <= FCS_CFG_ONE_RST;
        end else if (wr && paddr == FCS_ADDR_CFG_ONE) begin
            // Bits 3:0 stay fixed; protect flag always locked
            cfg_one_r <= (pwdata[15:0] & FCS_CFG_ONE_WMASK) | (FCS_CFG_ONE_RST & ~FCS_CFG_ONE_WMASK);
        end
    end

    assign read_mode_sel = cfg_one_r[FCS_CFG_RM];
    assign ecc_bypass = cfg_one_r[FCS_CFG_ECC];
    assign burst_size_sel = cfg_one_r[FCS_CFG_BL_HI:FCS_CFG_BL_LO];

    // ------------------------------------------------------------
    // Status snapshot
    // ------------------------------------------------------------
    // One-time lock caught once after reset release, never under reset
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            otp_seen_r <= 1'b0;
            status_r <= FCS_STATUS_RST;
        end else begin
            otp_seen_r <= otp_seen_r | otp_lock_in;
            status_r <= FCS_STATUS_RST;
            status_r[FCS_ST_ONGO] <= eng_busy;
            status_r[FCS_ST_LOCK] <= eng_lock;
            status_r[FCS_ST_LOAD] <= eng_load;
            status_r[FCS_ST_PROG] <= eng_prog;
            status_r[FCS_ST_ERASE] <= eng_erase;
            status_r[FCS_ST_ERR] <= eng_err;
            status_r[FCS_ST_SUS] <= eng_sus;
            status_r[FCS_ST_RST] <= eng_reset_busy;
            status_r[FCS_ST_ONETIME_BLOCK_LOCKED] <= otp_seen_r | otp_lock_in;
        end
    end

    // ------------------------------------------------------------
    // APB read path: zero-wait, reserved register reads zero
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_r <= !known_addr(paddr);
            // Writes to the status and reserved registers are dropped
            if (paddr == FCS_ADDR_CFG_ONE) begin
                prdata_r <= {16'h0000, cfg_one_r};
            end else if (paddr == FCS_ADDR_STATUS) begin
                prdata_r <= {16'h0000, status_r};
            end else begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r && acc;

    // ------------------------------------------------------------
    // Burst clock sampling and word counting
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bclk_s1_r <= 1'b0;
            bclk_s2_r <= 1'b0;
            bclk_s3_r <= 1'b0;
        end else begin
            bclk_s1_r <= burst_clk;
            bclk_s2_r <= bclk_s1_r;
            bclk_s3_r <= bclk_s2_r;
        end
    end

    // Burst ends after the configured count; if the host stops clocking early, burst_r stays set until the next start
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            burst_r <= 1'b0;
            words_left_r <= '0;
        end else if (burst_start && read_mode_sel) begin
            burst_r <= 1'b1;
            words_left_r <= burst_words(burst_size_sel);
        end else if (burst_r && bclk_rise) begin
            words_left_r <= words_left_r - FCS_CNT_W'(1);
            if (words_left_r == FCS_CNT_W'(1)) begin
                burst_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            word_r <= 1'b0;
            valid_r <= 1'b0;
        end else begin
            // Extra stage lets early ready lead the word without reading the first sync flop
            word_r <= burst_r && bclk_rise;
            valid_r <= word_r;
        end
    end

    assign burst_active = burst_r;
    assign data_valid = valid_r;

    // ------------------------------------------------------------
    // Ready and interrupt pins
    // ------------------------------------------------------------
    // Early ready leads the data-valid pulse by one cycle
    wire logic rdy_level = cfg_one_r[FCS_CFG_RDYCONF] ? word_r : (burst_r && bclk_rise);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdy_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            rdy_r <= cfg_one_r[FCS_CFG_READY_PIN_POLARITY] ? (rdy_level | ~burst_r) : ~(rdy_level | ~burst_r);
            irq_r <= cfg_one_r[FCS_CFG_IRQ_PIN_POLARITY] ? eng_int_ready : ~eng_int_ready;
        end
    end

    assign rdy_o = rdy_r;
    assign irq_o = irq_r;
    assign rdy_oe = cfg_one_r[FCS_CFG_OE];
    assign irq_oe = cfg_one_r[FCS_CFG_OE];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_cfg_reset_value;
        @(posedge ref_clk) $fell(rst) |-> cfg_one_r == FCS_CFG_ONE_RST;
    endproperty
    a_cfg_reset_value: assert property (p_cfg_reset_value) else $error("cfg reset value wrong");

    property p_protect_flag_zero;
        @(posedge ref_clk) disable iff (rst) cfg_one_r[FCS_CFG_BWP] == 1'b0 && cfg_one_r[3:1] == 3'b000;
    endproperty
    a_protect_flag_zero: assert property (p_protect_flag_zero) else $error("protect flag not zero");

    property p_oe_write;
        @(posedge ref_clk) disable iff (rst)
            (wr && paddr == FCS_ADDR_CFG_ONE) |=> rdy_oe == $past(pwdata[FCS_CFG_OE]) && irq_oe == rdy_oe;
    endproperty
    a_oe_write: assert property (p_oe_write) else $error("pin enable not following write");

    property p_oe_hold;
        @(posedge ref_clk) disable iff (rst)
            !(wr && paddr == FCS_ADDR_CFG_ONE) |=> $stable(rdy_oe);
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("pin enable changed without write");

    property p_irq_polarity;
        @(posedge ref_clk) disable iff (rst)
            ##1 irq_o == ($past(cfg_one_r[FCS_CFG_IRQ_PIN_POLARITY]) ? $past(eng_int_ready) : !$past(eng_int_ready));
    endproperty
    a_irq_polarity: assert property (p_irq_polarity) else $error("irq pin polarity wrong");

    property p_status_busy;
        @(posedge ref_clk) disable iff (rst) eng_busy |=> status_r[FCS_ST_ONGO];
    endproperty
    a_status_busy: assert property (p_status_busy) else $error("busy flag missed");

    property p_status_reserved;
        @(posedge ref_clk) disable iff (rst) status_r[8] == 1'b0 && status_r[5:0] == 6'h00;
    endproperty
    a_status_reserved: assert property (p_status_reserved) else $error("reserved status bit set");

    property p_status_ro;
        @(posedge ref_clk) disable iff (rst)
            (wr && paddr == FCS_ADDR_STATUS) |=> $stable(cfg_one_r);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write touched config");

    sequence s_burst4_start;
        burst_start && read_mode_sel && burst_size_sel == FCS_BL_4;
    endsequence
    property p_burst4_len;
        @(posedge ref_clk) disable iff (rst) s_burst4_start |=> words_left_r == FCS_CNT_W'(4) && burst_r;
    endproperty
    a_burst4_len: assert property (p_burst4_len) else $error("burst length load wrong");

    property p_async_no_burst;
        @(posedge ref_clk) disable iff (rst) (burst_start && !read_mode_sel && !burst_r) |=> !burst_r;
    endproperty
    a_async_no_burst: assert property (p_async_no_burst) else $error("burst in async mode");

    sequence s_cont_start;
        burst_start && read_mode_sel && burst_size_sel == FCS_BL_CONT;
    endsequence
    property p_cont_len;
        @(posedge ref_clk) disable iff (rst)
            s_cont_start |=> words_left_r == FCS_CNT_W'(CONT_WORDS) && burst_r;
    endproperty
    a_cont_len: assert property (p_cont_len) else $error("continuous burst length wrong");

    sequence s_last_word;
        burst_r && bclk_rise && !burst_start && words_left_r == FCS_CNT_W'(1);
    endsequence
    property p_burst_stop;
        @(posedge ref_clk) disable iff (rst) s_last_word |=> !burst_r;
    endproperty
    a_burst_stop: assert property (p_burst_stop) else $error("burst ran past its length");

    // Early ready: pin high one cycle, then the data-valid pulse
    sequence s_word_early;
        !cfg_one_r[FCS_CFG_RDYCONF] && cfg_one_r[FCS_CFG_READY_PIN_POLARITY] && burst_r && bclk_rise
            && !(wr && paddr == FCS_ADDR_CFG_ONE);
    endsequence
    sequence s_ready_then_data;
        rdy_o ##1 data_valid;
    endsequence
    property p_rdy_early;
        @(posedge ref_clk) disable iff (rst) s_word_early |=> s_ready_then_data;
    endproperty
    a_rdy_early: assert property (p_rdy_early) else $error("ready not one clock ahead of data");

    property p_rdy_with_data;
        @(posedge ref_clk) disable iff (rst)
            (cfg_one_r[FCS_CFG_RDYCONF] && cfg_one_r[FCS_CFG_READY_PIN_POLARITY] && word_r && !(wr && paddr == FCS_ADDR_CFG_ONE))
            |=> rdy_o && data_valid;
    endproperty
    a_rdy_with_data: assert property (p_rdy_with_data) else $error("ready not with data");

    // Sampled reset in the antecedent keeps the release edge out
    property p_rdy_idle;
        @(posedge ref_clk) disable iff (rst) (!rst && !burst_r) |=> rdy_o == $past(cfg_one_r[FCS_CFG_READY_PIN_POLARITY]);
    endproperty
    a_rdy_idle: assert property (p_rdy_idle) else $error("ready pin idle level wrong");

    property p_ecc_write;
        @(posedge ref_clk) disable iff (rst)
            (wr && paddr == FCS_ADDR_CFG_ONE) |=> ecc_bypass == $past(pwdata[FCS_CFG_ECC]);
    endproperty
    a_ecc_write: assert property (p_ecc_write) else $error("correction bypass not following write");

    property p_rm_write;
        @(posedge ref_clk) disable iff (rst)
            (wr && paddr == FCS_ADDR_CFG_ONE) |=> read_mode_sel == $past(pwdata[FCS_CFG_RM]);
    endproperty
    a_rm_write: assert property (p_rm_write) else $error("read mode not following write");

    property p_bsize_write;
        @(posedge ref_clk) disable iff (rst)
            (wr && paddr == FCS_ADDR_CFG_ONE) |=> burst_size_sel == $past(pwdata[FCS_CFG_BL_HI:FCS_CFG_BL_LO]);
    endproperty
    a_bsize_write: assert property (p_bsize_write) else $error("burst size not following write");

    property p_cfg2_zero;
        @(posedge ref_clk) disable iff (rst)
            (psel && !penable && paddr == FCS_ADDR_CFG_TWO) |=> prdata == 32'h0000_0000;
    endproperty
    a_cfg2_zero: assert property (p_cfg2_zero) else $error("reserved register not zero");

    property p_status_read;
        @(posedge ref_clk) disable iff (rst)
            (psel && !penable && paddr == FCS_ADDR_STATUS) |=> prdata == {16'h0000, $past(status_r)};
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read not one snapshot");

    property p_status_lock;
        @(posedge ref_clk) disable iff (rst) !rst |=> status_r[FCS_ST_LOCK] == $past(eng_lock);
    endproperty
    a_status_lock: assert property (p_status_lock) else $error("lock flag not mirrored");

    property p_status_ops;
        @(posedge ref_clk) disable iff (rst)
            !rst |=> status_r[FCS_ST_LOAD] == $past(eng_load) && status_r[FCS_ST_PROG] == $past(eng_prog)
                && status_r[FCS_ST_ERASE] == $past(eng_erase);
    endproperty
    a_status_ops: assert property (p_status_ops) else $error("operation flags not mirrored");

    property p_status_err;
        @(posedge ref_clk) disable iff (rst) !rst |=> status_r[FCS_ST_ERR] == $past(eng_err);
    endproperty
    a_status_err: assert property (p_status_err) else $error("error flag not mirrored");

    property p_status_sus;
        @(posedge ref_clk) disable iff (rst) !rst |=> status_r[FCS_ST_SUS] == $past(eng_sus);
    endproperty
    a_status_sus: assert property (p_status_sus) else $error("suspend flag not mirrored");

    property p_status_rst;
        @(posedge ref_clk) disable iff (rst) !rst |=> status_r[FCS_ST_RST] == $past(eng_reset_busy);
    endproperty
    a_status_rst: assert property (p_status_rst) else $error("reset busy flag not mirrored");

    property p_otp_catch;
        @(posedge ref_clk) disable iff (rst) otp_lock_in |=> status_r[FCS_ST_ONETIME_BLOCK_LOCKED];
    endproperty
    a_otp_catch: assert property (p_otp_catch) else $error("one-time lock missed");

    // Lock level is only refreshed by a reset, so it may never drop while running
    property p_otp_sticky;
        @(posedge ref_clk) disable iff (rst) status_r[FCS_ST_ONETIME_BLOCK_LOCKED] |=> status_r[FCS_ST_ONETIME_BLOCK_LOCKED];
    endproperty
    a_otp_sticky: assert property (p_otp_sticky) else $error("one-time lock dropped");
endmodule // fcs_regs

// *** verification/fcs_host_model.sv ***
// Host model that supplies the burst clock pin for synchronous reads
`timescale 1ns/1ps
module fcs_host_model (
    // Request from the bench
    input wire logic go,
    input wire logic [10:0] edges,
    // Burst clock pin
    output logic burst_clk
);
    // Stands low between frames; phase offset keeps it unrelated to ref_clk
    initial burst_clk = 1'b0;
    always @(posedge go) begin
        #3.1;
        repeat (edges) begin
            #62.5 burst_clk = 1'b1;
            #62.5 burst_clk = 1'b0;
        end
    end
endmodule // fcs_host_model

// *** verification/test_flash_config_status_regs.sv ***
// Self-checking bench for the flash configuration and status registers
`timescale 1ns/1ps
module test_flash_config_status_regs;
    import fcs_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [FCS_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, d;
    logic pready, pslverr, er, burst_clk, burst_start = 1'b0, otp_lock_in = 1'b0, go = 1'b0, otp_s = 1'b0;
    // Order: busy lock load prog erase err sus reset_busy int_ready
    logic [8:0] eng = '0;
    logic read_mode_sel, ecc_bypass, burst_active, data_valid, rdy_o, rdy_oe, irq_o, irq_oe;
    logic [2:0] burst_size_sel;
    logic [10:0] edges = '0;
    logic rc = 1'b0, rdy_prev = 1'b0;
    logic [31:0] seed = 32'h0000f467;
    int error_cnt = 0, check_count = 0, cyc = 0, dv_cnt = 0;

    always #4 ref_clk = ~ref_clk;

    fcs_regs u_fcs_regs (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .eng_busy(eng[8]), .eng_lock(eng[7]), .eng_load(eng[6]), .eng_prog(eng[5]), .eng_erase(eng[4]),
        .eng_err(eng[3]), .eng_sus(eng[2]), .eng_reset_busy(eng[1]), .eng_int_ready(eng[0]),
        .otp_lock_in(otp_lock_in), .burst_clk(burst_clk), .burst_start(burst_start),
        .read_mode_sel(read_mode_sel), .ecc_bypass(ecc_bypass), .burst_size_sel(burst_size_sel),
        .burst_active(burst_active), .data_valid(data_valid), .rdy_o(rdy_o), .rdy_oe(rdy_oe),
        .irq_o(irq_o), .irq_oe(irq_oe));
    fcs_host_model u_fcs_host_model (.go(go), .edges(edges), .burst_clk(burst_clk));

    // ------------------------------
    // Helpers
    // ------------------------------
    function automatic logic [31:0] xs();
        logic [31:0] x;
        x = seed;
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        seed = x;
        return x;
    endfunction

    // Bit 5 is outside this block's status fields, so it is left out of the comparison
    function automatic logic [31:0] st_exp(input logic [8:0] e, input logic o);
        return {16'h0, e[8:2], 1'b0, e[1], o, 6'h00};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        $display("Checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [FCS_AW-1:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        // Only the global timeout ends a wait for ready
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    // Host gives a known number of clocks; 16 ref cycles cover one burst clock period
    task automatic burst(input logic rm, input logic [2:0] code, input int words, input int clks);
        apb(1'b1, FCS_ADDR_CFG_ONE, {16'h0, rm, 3'b100, code, 4'b0111, rc, 4'h0});
        dv_cnt = 0;
        burst_start <= 1'b1;
        edges <= clks[10:0];
        @(posedge ref_clk);
        burst_start <= 1'b0;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (clks * 16 + 20) @(posedge ref_clk);
        chk("burst words", words, dv_cnt);
        chk("burst end", 0, burst_active);
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (data_valid === 1'b1) begin
            dv_cnt++;
            chk("ready before data", !rc, rdy_prev);
            if (rc) chk("ready with data", 1, rdy_o);
        end
        rdy_prev = rdy_o;
        if (cyc == 60000) begin
            error_cnt++;
            complete_run();
        end
    end

    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        apb(1'b0, FCS_ADDR_CFG_ONE, 32'h0);
        chk("cfg1 reset", 32'h40c0, rd);
        chk("pin oe reset", 0, {rdy_oe, irq_oe});
        apb(1'b0, FCS_ADDR_STATUS, 32'h0);
        chk("status reset", 0, rd);
        repeat (6) begin
            d = xs();
            d[11:9] = d[11] ? 3'b100 : d[11:9];
            apb(1'b1, FCS_ADDR_CFG_ONE, d);
            apb(1'b0, FCS_ADDR_CFG_ONE, 32'h0);
            chk("cfg1", {16'h0, d[15:0] & FCS_CFG_ONE_WMASK}, rd);
            chk("cfg outs", {d[15], d[8], d[11:9]}, {read_mode_sel, ecc_bypass, burst_size_sel});
        end
        apb(1'b1, FCS_ADDR_STATUS, 32'hffff);
        apb(1'b1, FCS_ADDR_CFG_TWO, 32'hffff);
        apb(1'b0, FCS_ADDR_STATUS, 32'h0);
        chk("status after write", 0, rd);
        chk("mapped err", 0, er);
        apb(1'b0, FCS_ADDR_CFG_TWO, 32'h0);
        chk("cfg2 reads zero", 0, rd);
        apb(1'b0, FCS_ADDR_CFG_ONE, 32'h0);
        chk("cfg1 kept", {16'h0, d[15:0] & FCS_CFG_ONE_WMASK}, rd);
        apb(1'b0, 18'h00010, 32'h0);
        chk("unmapped err", 1, er);
        repeat (10) begin
            d = xs();
            eng <= (cyc % 5 == 0) ? 9'h1ff : d[8:0];
            otp_lock_in <= d[20] & d[21];
            otp_s = otp_s | (d[20] & d[21]);
            repeat (3) @(posedge ref_clk);
            apb(1'b0, FCS_ADDR_STATUS, 32'h0);
            chk("status", st_exp(eng, otp_s), rd & 32'hffdf);
        end
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, FCS_ADDR_CFG_ONE, {24'h0, p[1], p[0], 1'b1, 5'h0});
            d = xs();
            eng[0] <= d[0];
            repeat (3) @(posedge ref_clk);
            chk("pin oe", 3, {rdy_oe, irq_oe});
            chk("irq pin", !(p[0] ^ eng[0]), irq_o);
            chk("ready pin", p[1], rdy_o);
        end
        apb(1'b1, FCS_ADDR_CFG_ONE, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk("pin oe off", 0, {rdy_oe, irq_oe});
        for (int i = 1; i <= 4; i++) begin
            rc = i[0];
            burst(1'b1, i[2:0], 4 << (i - 1), 4 << (i - 1));
        end
        rc = 1'b0;
        burst(1'b1, 3'b000, FCS_CONT_WORDS, FCS_CONT_WORDS);
        burst(1'b0, 3'b001, 0, 4);
        complete_run();
    end
endmodule // test_flash_config_status_regs
